// ### can_idf_defines.svh
// constants of the identifier acceptance filter: offsets, fields, reset values
// assumes a 32-bit classic wishbone register bus with byte addresses
//
// Summary of operation
// - code bits compared with identifier byte bits
// - comparison result masked by matching mask register
// - mask bits pick which code bits matter
// - reads anytime; code and mask writes only in init mode
// - two code banks of four, own masks
`ifndef CAN_IDF_DEFINES_SVH
`define CAN_IDF_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CAN_IDF_CODE_BASE 8'h00
`define CAN_IDF_MASK_BASE 8'h20
`define CAN_IDF_CTRL_OFS 8'h40
`define CAN_IDF_STAT_OFS 8'h44
`define CAN_IDF_ACC_CNT_OFS 8'h48
`define CAN_IDF_REJ_CNT_OFS 8'h4C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CAN_IDF_CTRL_INIT_REQ_BIT 0
`define CAN_IDF_CTRL_INIT_ACK_BIT 1
`define CAN_IDF_STAT_HIT_BIT 0
`define CAN_IDF_STAT_BANK0_BIT 1
`define CAN_IDF_STAT_BANK1_BIT 2
`define CAN_IDF_STAT_VALID_BIT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CAN_IDF_CODE_RST 8'h00
`define CAN_IDF_MASK_RST 8'h00
`define CAN_IDF_INIT_REQ_RST 1'b1
`define CAN_IDF_CNT_RST 16'h0000

`endif

// ### can_idf_filter.sv
// identifier acceptance filter with classic wishbone register slave
// assumes identifier bytes come from receive logic on the same clock
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps

`include "can_idf_defines.svh"

module can_idf_filter #(
    parameter int NUM_CODE = 8,
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic id_valid_i,
    input wire can_idf_pkg::can_idf_ident_t id_i,
    output can_idf_pkg::can_idf_result_t result_o,
    output logic init_acknowledge_o
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------

    // one byte: a mask bit of one means don't care
    function automatic logic byte_match(input logic [7:0] code,
                                        input logic [7:0] mask,
                                        input logic [7:0] id_byte);
        logic [7:0] diff;
        diff = code ^ id_byte;
        return ((diff & ~mask) == 8'h00);
    endfunction

    // one bank of four code and mask registers against the identifier
    function automatic logic bank_match(input logic [31:0] codes,
                                        input logic [31:0] masks,
                                        input can_idf_pkg::can_idf_ident_t ident);
        logic ok;
        ok = 1'b1;
        for (int b = 0; b < 4; b++) begin
            ok = ok & byte_match(codes[8*b +: 8], masks[8*b +: 8], ident[8*b +: 8]);
        end
        return ok;
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0] code_reg [0:NUM_CODE-1];
    logic [7:0] mask_reg [0:NUM_CODE-1];
    logic init_request_reg;
    can_idf_pkg::can_idf_mode_t mode_reg;
    can_idf_pkg::can_idf_mode_t mode_next;
    logic init_acknowledge_reg;
    can_idf_pkg::can_idf_result_t result_reg;
    logic [CNT_W-1:0] acc_cnt_reg;
    logic [CNT_W-1:0] rej_cnt_reg;
    logic [31:0] dat_reg;
    logic ack_reg;
    logic bus_req;
    logic bus_wr;
    logic bus_wr_lo;
    logic cfg_open;
    logic is_code;
    logic is_mask;
    logic [2:0] reg_idx;
    logic [31:0] bank0_code;
    logic [31:0] bank1_code;
    logic [31:0] bank0_mask;
    logic [31:0] bank1_mask;
    logic hit0;
    logic hit1;
    logic [31:0] rd_next;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign bus_wr = bus_req & wb_we_i;
    assign bus_wr_lo = bus_wr & wb_sel_i[0];
    assign is_code = (wb_adr_i[7:5] == 3'(`CAN_IDF_CODE_BASE >> 5)) && (wb_adr_i[1:0] == 2'b00);
    assign is_mask = (wb_adr_i[7:5] == 3'(`CAN_IDF_MASK_BASE >> 5)) && (wb_adr_i[1:0] == 2'b00);
    assign reg_idx = wb_adr_i[4:2];

    // both the request and its acknowledge must be set
    assign cfg_open = init_request_reg & init_acknowledge_reg;

    // ----------------------------------------------------------------
    // bank packing
    // ----------------------------------------------------------------
    assign bank0_code = {code_reg[3], code_reg[2], code_reg[1], code_reg[0]};
    assign bank1_code = {code_reg[7], code_reg[6], code_reg[5], code_reg[4]};
    assign bank0_mask = {mask_reg[3], mask_reg[2], mask_reg[1], mask_reg[0]};
    assign bank1_mask = {mask_reg[7], mask_reg[6], mask_reg[5], mask_reg[4]};
    assign hit0 = bank_match(bank0_code, bank0_mask, id_i);
    assign hit1 = bank_match(bank1_code, bank1_mask, id_i);

    // ----------------------------------------------------------------
    // code and mask registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CODE; i++) begin
                code_reg[i] <= `CAN_IDF_CODE_RST;
                mask_reg[i] <= `CAN_IDF_MASK_RST;
            end
        end else if (bus_wr_lo && cfg_open) begin
            if (is_code) begin
                code_reg[reg_idx] <= wb_dat_i[7:0];
            end
            if (is_mask) begin
                mask_reg[reg_idx] <= wb_dat_i[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // init request, written by software at any time
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_request_reg <= `CAN_IDF_INIT_REQ_RST;
        end else if (bus_wr_lo && wb_adr_i == `CAN_IDF_CTRL_OFS) begin
            init_request_reg <= wb_dat_i[`CAN_IDF_CTRL_INIT_REQ_BIT];
        end
    end

    // ----------------------------------------------------------------
    // init acknowledge handshake
    // ----------------------------------------------------------------
    // acknowledge rises two cycles after the request is set and falls one cycle
    // after it clears, after any filter pass in flight has been recorded
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            can_idf_pkg::CAN_IDF_RUN: begin
                if (init_request_reg) begin
                    mode_next = can_idf_pkg::CAN_IDF_ENTER;
                end
            end
            can_idf_pkg::CAN_IDF_ENTER: begin
                mode_next = init_request_reg ? can_idf_pkg::CAN_IDF_INIT
                                             : can_idf_pkg::CAN_IDF_RUN;
            end
            can_idf_pkg::CAN_IDF_INIT: begin
                if (!init_request_reg) begin
                    mode_next = can_idf_pkg::CAN_IDF_LEAVE;
                end
            end
            can_idf_pkg::CAN_IDF_LEAVE: begin
                mode_next = init_request_reg ? can_idf_pkg::CAN_IDF_INIT
                                             : can_idf_pkg::CAN_IDF_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= can_idf_pkg::CAN_IDF_INIT;
        end else begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_acknowledge_reg <= 1'b1;
        end else begin
            init_acknowledge_reg <= (mode_next == can_idf_pkg::CAN_IDF_INIT);
        end
    end

    // ----------------------------------------------------------------
    // filter pass
    // ----------------------------------------------------------------
    // identifiers offered while in init mode are not filtered: the
    // tables may be half written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_reg <= '0;
        end else if (id_valid_i && !init_acknowledge_reg) begin
            result_reg.valid <= 1'b1;
            result_reg.bank0_hit <= hit0;
            result_reg.bank1_hit <= hit1;
            result_reg.hit <= hit0 | hit1;
        end else begin
            result_reg.valid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // accept and reject counters, cleared by a write to them unless a count lands in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_cnt_reg <= CNT_W'(`CAN_IDF_CNT_RST);
        end else if (result_reg.valid && result_reg.hit) begin
            acc_cnt_reg <= acc_cnt_reg + CNT_W'(1);
        end else if (bus_wr && wb_adr_i == `CAN_IDF_ACC_CNT_OFS) begin
            acc_cnt_reg <= CNT_W'(`CAN_IDF_CNT_RST);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rej_cnt_reg <= CNT_W'(`CAN_IDF_CNT_RST);
        end else if (result_reg.valid && !result_reg.hit) begin
            rej_cnt_reg <= rej_cnt_reg + CNT_W'(1);
        end else if (bus_wr && wb_adr_i == `CAN_IDF_REJ_CNT_OFS) begin
            rej_cnt_reg <= CNT_W'(`CAN_IDF_CNT_RST);
        end
    end

    // ----------------------------------------------------------------
    // read mux, readable at any time
    // ----------------------------------------------------------------
    always_comb begin
        rd_next = 32'h0000_0000;
        if (is_code) begin
            rd_next[7:0] = code_reg[reg_idx];
        end else if (is_mask) begin
            rd_next[7:0] = mask_reg[reg_idx];
        end else begin
            unique case (wb_adr_i)
                `CAN_IDF_CTRL_OFS: begin
                    rd_next[`CAN_IDF_CTRL_INIT_REQ_BIT] = init_request_reg;
                    rd_next[`CAN_IDF_CTRL_INIT_ACK_BIT] = init_acknowledge_reg;
                end
                `CAN_IDF_STAT_OFS: begin
                    rd_next[`CAN_IDF_STAT_HIT_BIT] = result_reg.hit;
                    rd_next[`CAN_IDF_STAT_BANK0_BIT] = result_reg.bank0_hit;
                    rd_next[`CAN_IDF_STAT_BANK1_BIT] = result_reg.bank1_hit;
                    rd_next[`CAN_IDF_STAT_VALID_BIT] = result_reg.valid;
                end
                `CAN_IDF_ACC_CNT_OFS: begin
                    rd_next[CNT_W-1:0] = acc_cnt_reg;
                end
                `CAN_IDF_REJ_CNT_OFS: begin
                    rd_next[CNT_W-1:0] = rej_cnt_reg;
                end
                default: begin
                    rd_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // wishbone answer: one cycle after the strobe, every address
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            dat_reg <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign result_o = result_reg;
    assign init_acknowledge_o = init_acknowledge_reg;

endmodule

// ### can_idf_filter_sva.sv
// assertions on the ports of the acceptance filter
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module can_idf_filter_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic id_valid_i,
    input wire can_idf_pkg::can_idf_result_t result_o,
    input wire logic init_acknowledge_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    chk_bus_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    chk_pass_latency: assert property (
        id_valid_i && !init_acknowledge_o |=> result_o.valid) else $error("no result");
    chk_init_block: assert property (
        id_valid_i && init_acknowledge_o |=> !result_o.valid) else $error("pass in init");
    chk_valid_cause: assert property (
        result_o.valid |-> $past(id_valid_i) && !$past(init_acknowledge_o))
        else $error("stray result");
    chk_hit_either: assert property (
        result_o.valid |-> result_o.hit == (result_o.bank0_hit || result_o.bank1_hit))
        else $error("hit not bank or");
    chk_hit_hold: assert property (
        !result_o.valid |-> $stable(result_o[2:0])) else $error("hit moved");
    cover property (result_o.valid && result_o.bank0_hit);
    cover property (result_o.valid && result_o.bank1_hit);
    cover property (id_valid_i && init_acknowledge_o);
endmodule

// ### can_idf_pkg.sv
// types shared by the identifier acceptance filter
// assumes nothing beyond a systemverilog compiler
package can_idf_pkg;

    // four received identifier bytes, byte 3 first, byte 0 in the low bits
    typedef struct packed {
        logic [7:0] id_byte_3;
        logic [7:0] id_byte_2;
        logic [7:0] id_byte_1;
        logic [7:0] id_byte_0;
    } can_idf_ident_t;

    // result of one filter pass
    typedef struct packed {
        logic valid;
        logic bank1_hit;
        logic bank0_hit;
        logic hit;
    } can_idf_result_t;

    // init mode handshake of the bank registers
    typedef enum logic [1:0] {
        CAN_IDF_RUN = 2'b00,
        CAN_IDF_ENTER = 2'b01,
        CAN_IDF_INIT = 2'b10,
        CAN_IDF_LEAVE = 2'b11
    } can_idf_mode_t;

endpackage

// ### can_idf_rx_model.sv
// receive buffer model: hands identifier bytes to the filter
// assumes the bench asks for a pass one cycle ahead
`timescale 1ns/1ps
module can_idf_rx_model (
    input wire logic clk_i,
    input wire logic send_i,
    input wire can_idf_pkg::can_idf_ident_t frame_i,
    output logic id_valid_o,
    output can_idf_pkg::can_idf_ident_t id_o
);
    initial id_valid_o = 1'b0;
    initial id_o = '0;
    always @(posedge clk_i) begin
        id_valid_o <= send_i;
        // between passes the bytes toggle to the complement of the last value, so stale data keeps changing
        id_o <= send_i ? frame_i : ~id_o;
    end
endmodule

// ### test_can_id_acceptance_filter.sv
// self-checking bench of the acceptance filter
// assumes the checker and receive model files are compiled first
`timescale 1ns/1ps
module test_can_id_acceptance_filter;
    logic clk = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'h0;
    int n_acc = 0;
    int n_rej = 0;
    logic [2:0] last_hits = 3'b000;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack;
    logic init_ack;
    logic send = 1'b0;
    logic id_valid;
    can_idf_pkg::can_idf_ident_t frame = '0;
    can_idf_pkg::can_idf_ident_t id;
    can_idf_pkg::can_idf_result_t res;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int code[8];
    int mask[8];
    logic [15:0] seed = 16'h0007;
    logic [31:0] f;
    logic [31:0] g;
    can_idf_filter can_idf_filter_i (.clk_i(clk), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .id_valid_i(id_valid), .id_i(id),
        .result_o(res), .init_acknowledge_o(init_ack));
    can_idf_rx_model can_idf_rx_model_i (.clk_i(clk), .send_i(send), .frame_i(frame),
        .id_valid_o(id_valid), .id_o(id));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        logic [31:0] v;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        v[31:16] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        v[15:0] = seed;
        return v;
    endfunction
    task automatic compare(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= {24'h00_0000, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic read_check(input logic [7:0] a, input int e);
        bus(1'b0, a, 8'h00);
        compare($sformatf("reg %h", a), 32'(e & 8'hFF), rd);
    endtask
    task automatic pass_check(input logic [31:0] v, input logic open);
        logic [2:0] e;
        e = 3'b000;
        for (int b = 0; b < 2; b++) begin
            e[b + 1] = 1'b1;
            for (int n = 0; n < 4; n++)
                if (((v[8 * n +: 8] ^ code[4 * b + n]) & ~mask[4 * b + n] & 8'hFF) != 0)
                    e[b + 1] = 1'b0;
        end
        e[0] = e[1] | e[2];
        @(posedge clk);
        send <= 1'b1;
        frame <= v;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
        compare("valid", {31'h0, open}, {31'h0, res.valid});
        if (open) begin
            compare("hits", {29'h0, e}, {29'h0, res[2:0]});
            last_hits = e;
            if (e[0]) n_acc++;
            else n_rej++;
        end
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_i <= 1'b0;
        read_check(8'h40, 3);
        for (int i = 0; i < 16; i++) read_check(8'(4 * i), 0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            f = rnd();
            if (i == 9 || i == 13) f[2:0] = 3'b111;
            if (i == 11 || i == 15) f[2:0] = 3'b111;
            if (i < 8) code[i] = f[7:0];
            else mask[i - 8] = f[7:0];
            bus(1'b1, 8'(4 * i), f[7:0]);
        end
        for (int i = 0; i < 16; i++) read_check(8'(4 * i), i < 8 ? code[i] : mask[i - 8]);
        f = rnd();
        pass_check(f, 1'b0);
        $display("init test done");
        bus(1'b1, 8'h40, 8'h00);
        while (init_ack !== 1'b0) @(posedge clk);
        read_check(8'h40, 0);
        bus(1'b1, 8'h00, ~code[0][7:0]);
        read_check(8'h00, code[0]);
        read_check(8'h80, 0);
        $display("lock test done");
        for (int k = 0; k < 24; k++) begin
            f = rnd();
            g = f;
            if (k % 3 != 0)
                for (int n = 0; n < 4; n++)
                    g[8 * n +: 8] = code[4 * (k % 2) + n][7:0]
                        ^ (f[8 * n +: 8] & mask[4 * (k % 2) + n][7:0]);
            pass_check(g, 1'b1);
        end
        $display("filter test done");
        read_check(8'h44, {29'h0, last_hits});
        read_check(8'h48, n_acc);
        read_check(8'h4C, n_rej);
        bus(1'b1, 8'h48, 8'h00);
        read_check(8'h48, 0);
        $display("count test done");
        stop_test();
    end
endmodule
bind can_idf_filter can_idf_filter_sva can_idf_filter_sva_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .id_valid_i(id_valid_i),
    .result_o(result_o), .init_acknowledge_o(init_acknowledge_o));
